// file: src/dac_bus_master.sv
// Serial bus master that sends one word per request to the converter
`timescale 1ns/1ps
`default_nettype none
module dac_bus_master
    import dac_link_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    dac_link_if.host link,
    // User request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [dac_link_pkg::WORD_W-1:0] req_word,
    input wire logic [dac_link_pkg::BITCNT_W-1:0] req_bits,
    input wire logic use_strobe,
    // Status
    output logic done
);
    import dac_link_pkg::*;

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_LOW  = 5'b00010,
        S_HIGH = 5'b00100,
        S_GAP  = 5'b01000,
        S_LOAD = 5'b10000
    } state_t;

    state_t state_ff, nxt_state;
    logic [WORD_W-1:0] data_ff, nxt_data;      // Outgoing word, top bit on pin
    logic [BITCNT_W-1:0] bits_ff, nxt_bits;    // Clocks left in the frame
    logic [TIMER_W-1:0] tmr_ff, nxt_tmr;       // Phase timer
    logic strobe_ff, nxt_strobe;               // Strobe use for this frame
    logic cs_ff, nxt_cs, sclk_ff, nxt_sclk, ld_ff, nxt_ld, done_ff, nxt_done;

    // Next state: data change on falling clock, sampled by rising
    always_comb
    begin
        nxt_state = state_ff;
        nxt_data = data_ff;
        nxt_bits = bits_ff;
        nxt_tmr = (tmr_ff == '0) ? '0 : tmr_ff - 1'b1;
        nxt_strobe = strobe_ff;
        nxt_cs = cs_ff;
        nxt_sclk = sclk_ff;
        nxt_ld = ld_ff;
        nxt_done = 1'b0;
        case (state_ff)
            S_IDLE:
            begin
                if (req_valid)
                begin
                    // Long frames are padded with zeros at the low end
                    nxt_data = req_word;
                    nxt_bits = (req_bits == '0) ? BITCNT_W'(WORD_W) : req_bits;
                    nxt_strobe = use_strobe;
                    nxt_cs = 1'b0;
                    // Strobe goes high as select falls when used; a tied frame keeps it
                    nxt_ld = use_strobe ? 1'b1 : ld_ff;
                    nxt_tmr = TIMER_W'(SCLK_HALF_CYC);
                    nxt_state = S_LOW;
                end
            end
            S_LOW:
            begin
                if (tmr_ff == '0)
                begin
                    nxt_sclk = 1'b1;
                    nxt_tmr = TIMER_W'(SCLK_HALF_CYC);
                    nxt_state = S_HIGH;
                end
            end
            S_HIGH:
            begin
                if (tmr_ff == '0)
                begin
                    nxt_sclk = 1'b0;
                    nxt_data = {data_ff[WORD_W-2:0], 1'b0};
                    nxt_bits = bits_ff - 1'b1;
                    nxt_tmr = TIMER_W'(SCLK_HALF_CYC);
                    nxt_state = (bits_ff == 5'h01) ? S_GAP : S_LOW;
                    // Raise select right after the last clock
                    if (bits_ff == 5'h01)
                    begin
                        nxt_cs = 1'b1;
                        nxt_tmr = TIMER_W'(CS_GAP_CYC);
                    end
                end
            end
            S_GAP:
            begin
                if (tmr_ff == '0)
                begin
                    if (strobe_ff)
                    begin
                        nxt_ld = 1'b0;
                        nxt_tmr = TIMER_W'(LOAD_W_CYC);
                        nxt_state = S_LOAD;
                    end
                    else
                    begin
                        // Tied strobe drops with select high and then stays low
                        nxt_ld = 1'b0;
                        nxt_done = 1'b1;
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_LOAD:
            begin
                if (tmr_ff == '0)
                begin
                    nxt_ld = 1'b1;
                    nxt_done = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            default:
            begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // Register the sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff <= S_IDLE;
            data_ff <= 16'h0000;
            bits_ff <= 5'h00;
            tmr_ff <= 8'h00;
            strobe_ff <= 1'b1;
            cs_ff <= 1'b1;
            sclk_ff <= 1'b0;
            ld_ff <= 1'b1;
            done_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            data_ff <= nxt_data;
            bits_ff <= nxt_bits;
            tmr_ff <= nxt_tmr;
            strobe_ff <= nxt_strobe;
            cs_ff <= nxt_cs;
            sclk_ff <= nxt_sclk;
            ld_ff <= nxt_ld;
            done_ff <= nxt_done;
        end
    end

    // Pins come straight from flip-flops
    assign link.cs_n = cs_ff;
    assign link.sclk = sclk_ff;
    assign link.sdi = data_ff[WORD_W-1];
    assign link.latch_load_strobe_n = ld_ff;
    assign req_ready = (state_ff == S_IDLE);
    assign done = done_ff;
endmodule
`default_nettype wire

// file: src/dac_link_pkg.sv
// Shared constants for the serial converter load link
package dac_link_pkg;
    // Word width and frame length
    localparam int WORD_W = 16;
    // Segment decode split: upper bits thermometer coded, rest to ladder
    localparam int SEG_BITS = 4;
    localparam int SEG_CTRL_W = 15;
    localparam int LADDER_W = 12;
    // Mid-scale power-on value, only the top bit set
    localparam logic [15:0] MID_SCALE = 16'h8000;
    // Shift register has no defined value; model it with a plain constant
    localparam logic [15:0] SHIFT_RESET = 16'h0000;
    // Bench link clock period, host clock period and link half period in host cycles
    localparam int LINK_PERIOD_NS = 125;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_CYC = (LINK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Host gap with chip select high between frames, in ns and cycles
    localparam int CS_GAP_NS = 30;
    localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Load strobe low width, in ns and cycles
    localparam int LOAD_W_NS = 30;
    localparam int LOAD_W_CYC = (LOAD_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Host count widths
    localparam int BITCNT_W = 5;
    localparam int TIMER_W = 8;
endpackage

// file: src/dac_link_if.sv
// Interface joining the serial bus master and the converter front end
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
    logic cs_n;                  // Chip select, active low
    logic sclk;                  // Serial clock
    logic sdi;                   // Serial data, most significant bit first
    logic latch_load_strobe_n;   // Latch load strobe, active low
    // Converter end
    modport device (input cs_n, input sclk, input sdi, input latch_load_strobe_n);
    // Bus master end
    modport host (output cs_n, output sclk, output sdi, output latch_load_strobe_n);
endinterface
`default_nettype wire

// file: src/dac_front_end.sv
// Converter front end: serial shift, input register, latch and switch decode
`timescale 1ns/1ps
`default_nettype none
module dac_front_end
    import dac_link_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    dac_link_if.device link,
    // Modelled analog controls
    output logic [dac_link_pkg::WORD_W-1:0] latch_code,
    output logic [dac_link_pkg::SEG_CTRL_W-1:0] segment_switch_controls,
    output logic [dac_link_pkg::LADDER_W-1:0] ladder_switch_controls,
    output logic [dac_link_pkg::WORD_W-1:0] input_word
);
    import dac_link_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Every pin comes from another domain, so it passes two flops first.
    // This costs about three cycles from pin edge to register update, which
    // is traded for clean edges; the link clock must stay slow enough.
    // Bit order in the chain: [3] select, [2] clock, [1] data, [0] strobe.
    logic [3:0] meta_ff, nxt_meta;     // First stage, read only by second
    logic [3:0] sync_ff, nxt_sync;     // Second stage: cs_n, sclk, sdi, strobe
    logic sclk_d_ff, nxt_sclk_d;       // Delayed clock for edge finding
    logic cs_d_ff, nxt_cs_d;           // Delayed select for edge finding

    // Next values of the synchroniser chain
    // Delayed copies give the previous level for edge finding
    always_comb
    begin
        nxt_meta = {link.cs_n, link.sclk, link.sdi, link.latch_load_strobe_n};
        nxt_sync = meta_ff;
        nxt_sclk_d = sync_ff[2];
        nxt_cs_d = sync_ff[3];
    end

    // Register the chain
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Reset to the idle levels of the pins: select and strobe high,
            // clock and data low, so no false edge follows reset
            meta_ff <= 4'h9;
            sync_ff <= 4'h9;
            sclk_d_ff <= 1'b0;                // Matches the idle clock level
            cs_d_ff <= 1'b1;                  // Matches the idle select level
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            sclk_d_ff <= nxt_sclk_d;
            cs_d_ff <= nxt_cs_d;
        end
    end

    // Decoded edges from the synchronised pins
    logic cs_n_s, sclk_rise, cs_rise, strobe_low;
    // Synchronised select level
    assign cs_n_s = sync_ff[3];
    // Link clock rising edge, one cycle wide
    assign sclk_rise = sync_ff[2] && !sclk_d_ff;
    // Select rising edge, one cycle wide
    assign cs_rise = sync_ff[3] && !cs_d_ff;
    // Strobe is a level, not an edge
    assign strobe_low = !sync_ff[0];

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    // Three stages: shift, input and latch. The input register decouples
    // the serial frame from the latch, so the latch only ever sees whole
    // words, either on the strobe or right after the load.
    logic [WORD_W-1:0] shift_ff, nxt_shift;   // Serial shift register
    logic [WORD_W-1:0] input_ff, nxt_input;   // Input register
    logic [WORD_W-1:0] latch_ff, nxt_latch;   // Converter latch

    // Shift, load and latch update
    always_comb
    begin
        // Default: every register holds its value
        nxt_shift = shift_ff;
        nxt_input = input_ff;
        nxt_latch = latch_ff;
        // Sample on rising serial clock only while selected
        if (!cs_n_s && sclk_rise)
        begin
            // Older bits fall off the top: last sixteen kept, short leaves stale
            nxt_shift = {shift_ff[WORD_W-2:0], sync_ff[1]};
        end
        // A cut frame is not detected here; the master must resend
        // Select rising moves the whole word to the input register
        if (cs_rise)
        begin
            nxt_input = shift_ff;
        end
        // Strobe low with select high copies input register; strobe tied low follows the load
        // a cycle later, which stands for the immediate update
        if (strobe_low && cs_n_s)
        begin
            nxt_latch = input_ff;
        end
    end

    // Input register and latch: both preset to mid-scale
    // The shift register is kept apart, as it has no real reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Power-on code stands until the first load
            input_ff <= MID_SCALE;
            latch_ff <= MID_SCALE;
        end
        else
        begin
            input_ff <= nxt_input;
            latch_ff <= nxt_latch;
        end
    end

    // Shift register: no reset effect beyond a modelling constant
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Real register powers up undefined; a fixed constant keeps
            // the model free of unknowns, so a short first frame stays visible
            shift_ff <= SHIFT_RESET;
        end
        else
        begin
            shift_ff <= nxt_shift;
        end
    end

    // ------------------------------------------------------------
    // Switch decode
    // ------------------------------------------------------------
    // The switch controls trail the latch by one cycle; registering them
    // avoids decode glitches on the switches at the price of that cycle.
    // Thermometer coding means one more segment per step of the top nibble.
    logic [SEG_CTRL_W-1:0] seg_ff, nxt_seg;   // Segment switch controls
    logic [LADDER_W-1:0] lad_ff, nxt_lad;     // Ladder switch controls

    // Thermometer: segment k on when top nibble exceeds k, unsigned code
    always_comb
    begin
        for (int k = 0; k < SEG_CTRL_W; k++)
        begin
            nxt_seg[k] = (int'(latch_ff[WORD_W-1 -: SEG_BITS]) > k);
        end
        // Low twelve bits drive the ladder directly
        nxt_lad = latch_ff[LADDER_W-1:0];
    end

    // Register the switch controls so they are glitch free
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Match the decode of the mid-scale latch code
            seg_ff <= 15'h00FF;   // Mid-scale: top nibble eight
            lad_ff <= 12'h000;    // Mid-scale: low bits clear
        end
        else
        begin
            seg_ff <= nxt_seg;
            lad_ff <= nxt_lad;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Exposed state in place of the analog output; all come from flops
    assign latch_code = latch_ff;
    assign segment_switch_controls = seg_ff;
    assign ladder_switch_controls = lad_ff;
    assign input_word = input_ff;
endmodule
`default_nettype wire

// file: dv/dac_link_assertions.sv
// Checker of the serial load link and the converter outputs
`timescale 1ns/1ps
`default_nettype none
module dac_link_assertions
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link signals
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic latch_load_strobe_n,
    // Converter outputs
    input wire logic [dac_link_pkg::WORD_W-1:0] latch_code,
    input wire logic [dac_link_pkg::SEG_CTRL_W-1:0] segment_switch_controls,
    input wire logic [dac_link_pkg::LADDER_W-1:0] ladder_switch_controls,
    input wire logic [dac_link_pkg::WORD_W-1:0] input_word
);
    import dac_link_pkg::*;
    // ----------------------------------------
    // Shadow of the shift register
    // ----------------------------------------
    logic sclk_q_ff; // Link clock seen last cycle
    logic [15:0] shadow_ff; // Expected shift content
    logic [15:0] nxt_shadow;
    // Shift on a seen rise while selected; raw pins, so no sync lag
    always_comb
    begin
        nxt_shadow = shadow_ff;
        if (sclk && !sclk_q_ff && !cs_n)
        begin
            nxt_shadow = {shadow_ff[14:0], sdi};
        end
    end
    // Register the shadow
    always_ff @(posedge clk)
    begin
        sclk_q_ff <= rst_n ? sclk : 1'b0;
        shadow_ff <= rst_n ? nxt_shadow : SHIFT_RESET;
    end
    // Expected segment pattern: bit k set when nibble above k
    function automatic logic [14:0] thermo(input logic [3:0] n);
        for (int k = 0; k < 15; k++) thermo[k] = (n > k);
    endfunction
    // Latch fields as plain signals so their history can be taken
    logic [3:0] code_top;
    logic [11:0] code_low;
    assign code_top = latch_code[15:12];
    assign code_low = latch_code[11:0];
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence cs_rise;
        $rose(cs_n);
    endsequence
    sequence word_loaded;
        ##[1:6] (input_word == shadow_ff);
    endsequence
    a_mid_scale: assert property ($rose(rst_n) |->
        latch_code == MID_SCALE && input_word == MID_SCALE)
        else $error("power-on value is not mid-scale");
    a_load_word: assert property (cs_rise |-> word_loaded)
        else $error("input register missed the shifted word");
    a_tied_update: assert property ($rose(cs_n) && !latch_load_strobe_n
        |-> ##[1:8] latch_code == shadow_ff)
        else $error("latch did not follow load with strobe low");
    a_strobe_copy: assert property ($fell(latch_load_strobe_n)
        |-> ##[1:6] latch_code == input_word)
        else $error("strobe did not copy input register");
    a_seg_decode: assert property (segment_switch_controls == thermo($past(code_top)))
        else $error("segment controls do not match latch");
    a_ladder_bits: assert property (ladder_switch_controls == $past(code_low))
        else $error("ladder controls do not match latch");
    a_strobe_high: assert property (!cs_n && $past(latch_load_strobe_n) |-> latch_load_strobe_n)
        else $error("strobe fell while selected");
    a_sdi_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(sdi) |-> $fell(sclk))
        else $error("data changed off a falling clock");
    a_sclk_phase: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("link clock high phase wrong");
    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("link clock high while deselected");
    a_input_hold: assert property (cs_n [*8] |-> $stable(input_word))
        else $error("input register moved while deselected");
endmodule
`default_nettype wire

// file: dv/serial_dac_load_logic_test.sv
// Self-checking bench of bus master and converter front end
`timescale 1ns/1ps
`default_nettype none
module serial_dac_load_logic_test;
    import dac_link_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic [15:0] req_word = 16'h0000;
    logic [4:0] req_bits = 5'h00;
    logic use_strobe = 1'b1;
    logic req_ready;
    logic done;
    logic [15:0] latch_code, input_word, latch_b, input_b;
    logic [14:0] seg;
    logic [11:0] ladder;
    logic [15:0] codes [4] = '{16'h0000, 16'hFFFF, 16'h0001, 16'h8000};
    int fails = 0;
    int samples_checked = 0;
    int rises = 0; // Link clock rises in the current frame
    int last_rises = 0; // Rises of the last finished frame
    logic sclk_q = 1'b0;
    logic cs_q = 1'b1;
    dac_link_if link();
    dac_link_if link_b(); // Driven by the bench to break the rules
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    dac_bus_master u_dac_bus_master (.clk(clk), .rst_n(rst_n), .link(link.host),
        .req_valid(req_valid), .req_ready(req_ready), .req_word(req_word),
        .req_bits(req_bits), .use_strobe(use_strobe), .done(done));
    dac_front_end u_dac_front_end (.clk(clk), .rst_n(rst_n), .link(link.device),
        .latch_code(latch_code), .segment_switch_controls(seg),
        .ladder_switch_controls(ladder), .input_word(input_word));
    dac_front_end u_dac_front_end_2 (.clk(clk), .rst_n(rst_n), .link(link_b.device),
        .latch_code(latch_b), .segment_switch_controls(), .ladder_switch_controls(),
        .input_word(input_b));
    dac_link_assertions u_dac_link_assertions (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n),
        .sclk(link.sclk), .sdi(link.sdi), .latch_load_strobe_n(link.latch_load_strobe_n),
        .latch_code(latch_code), .segment_switch_controls(seg),
        .ladder_switch_controls(ladder), .input_word(input_word));
    // Count link clock rises per frame
    always @(posedge clk)
    begin
        sclk_q <= link.sclk;
        cs_q <= link.cs_n;
        if (link.sclk && !sclk_q && !link.cs_n)
            rises <= rises + 1;
        if (link.cs_n && !cs_q)
        begin
            last_rises <= rises;
            rises <= 0;
        end
    end
    function automatic logic [14:0] thermo(input logic [3:0] n);
        for (int k = 0; k < 15; k++) thermo[k] = (n > k);
    endfunction
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // All outputs of the first front end against one word
    task automatic expect_out(input logic [15:0] w);
        check("input_word", w, input_word);
        check("latch_code", w, latch_code);
        check("segments", {1'b0, thermo(w[15:12])}, {1'b0, seg});
        check("ladder", {4'h0, w[11:0]}, {4'h0, ladder});
    endtask
    // One request to the master, then wait for its done pulse
    task automatic send(input logic [15:0] w, input logic [4:0] n, input logic s);
        int t;
        req_valid = 1'b1;
        req_word = w;
        req_bits = n;
        use_strobe = s;
        t = 0;
        while (req_ready !== 1'b1 && t < 100)
        begin
            @(posedge clk);
            #1;
            t++;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        check("req_ready", 16'h0000, {15'h0000, req_ready});
        while (done !== 1'b1 && t < 3000)
        begin
            @(posedge clk);
            #1;
            t++;
        end
        if (done !== 1'b1)
        begin
            fails++;
            tally_and_finish();
        end
        else
        begin
            // Latch follows a few cycles after select rises in tied mode
            repeat (4) @(posedge clk);
            #1;
        end
    endtask
    // Bench frame on the second link, own unrelated clock phase
    task automatic bang(input logic [15:0] w, input logic sel_n);
        link_b.cs_n = sel_n;
        for (int i = 0; i < 16; i++)
        begin
            link_b.sdi = w[15-i];
            #62.5 link_b.sclk = 1'b1;
            #62.5 link_b.sclk = 1'b0;
        end
        #62.5 link_b.cs_n = 1'b1;
        link_b.sdi = ~link_b.sdi;
        repeat (8) @(posedge clk);
        #1;
    endtask
    initial
    begin
        link_b.cs_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.sdi = 1'b0;
        link_b.latch_load_strobe_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        expect_out(MID_SCALE);
        $display("Test power-on done");
        send(16'hA5C3, 5'h10, 1'b1);
        check("clock_count", 16'h0010, last_rises[15:0]);
        expect_out(16'hA5C3);
        $display("Test strobed load done");
        foreach (codes[i])
        begin
            send(codes[i], 5'h00, 1'b0);
            expect_out(codes[i]);
        end
        $display("Test tied strobe done");
        send(16'h1234, 5'h14, 1'b0);
        check("clock_count", 16'h0014, last_rises[15:0]);
        expect_out(16'h2340);
        send(16'hAB00, 5'h08, 1'b0);
        expect_out(16'h40AB);
        send(16'h4321, 5'h10, 1'b0);
        expect_out(16'h4321);
        $display("Test long and short frames done");
        bang(16'hFFFF, 1'b1);
        check("ignored_input", MID_SCALE, input_b);
        bang(16'h00FF, 1'b0);
        check("second_input", 16'h00FF, input_b);
        check("latch_held", MID_SCALE, latch_b);
        link_b.latch_load_strobe_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("latch_strobed", 16'h00FF, latch_b);
        $display("Test bench driven link done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
